// ---- hdl/crf_core.sv ----
// programmer-visible register file, flag byte and alignment logic
// ============================================================
`timescale 1ns/1ps
`default_nettype none
`include "crf_params.svh"

module crf_core
  import crf_pkg::*;
#(
  parameter int REG_CNT = `CRF_REG_CNT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] reset_vector,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire crf_size_e   wr_size,
  input  wire logic [15:0] wr_data,
  input  wire logic [2:0]  rd_idx,
  input  wire crf_size_e   rd_size,
  input  wire logic [2:0]  addr_idx,
  input  wire logic        alu_go,
  input  wire crf_op_e     alu_op,
  input  wire logic        alu_word,
  input  wire logic [2:0]  alu_dst,
  input  wire logic [2:0]  alu_src,
  input  wire logic [7:0]  alu_imm,
  input  wire logic        alu_use_imm,
  input  wire logic [2:0]  bit_num,
  input  wire logic        bit_inv,
  input  wire logic        small_two,
  input  wire crf_flsrc_e  flag_src,
  input  wire logic [7:0]  flag_wdata,
  input  wire logic [15:0] pop_word,
  input  wire logic        push_req,
  input  wire logic        push_flags,
  input  wire logic        pop_req,
  input  wire logic        irq_entry,
  input  wire logic        ip_load,
  input  wire logic [15:0] ip_target,
  input  wire logic        ip_step,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic        mem_word,
  input  wire crf_cond_e   cond_sel,
  output logic [15:0]      rd_data,
  output logic [15:0]      addr_out,
  output logic [15:0]      ip_out,
  output logic [7:0]       flag_byte_register,
  output logic [15:0]      stack_top_pointer,
  output logic [15:0]      stack_addr,
  output logic [15:0]      stack_wdata,
  output logic [15:0]      mem_addr_out,
  output logic             int_masked,
  output logic             cond_true
);

  // ==========================================================
  // elaboration checks
  initial begin
    if (REG_CNT != `CRF_REG_CNT)
      $error("crf_core: register count must be eight");
  end

  // ==========================================================
  // storage
  // general registers carry no reset: contents stay undefined
  logic [15:0] gpr_reg [`CRF_REG_CNT];
  logic [15:0] ip_reg;
  logic [7:0]  flag_reg;
  // mask bit and the rest live in separate registers: only the mask resets
  logic        flag_mask_reg;
  logic [6:0]  flag_rest_reg;
  assign flag_reg = {flag_mask_reg, flag_rest_reg};
  logic [15:0] sp_val;

  assign sp_val = gpr_reg[`CRF_STACK_IDX];

  // ==========================================================
  // arithmetic and flag generation
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [15:0] res;
  logic        c_out;
  logic        h_out;
  logic        v_out;
  logic        c_new;
  logic        h_new;
  logic        v_new;
  logic        flags_arith;
  logic        cin;
  logic [16:0] sum17;
  logic [12:0] sum13;
  logic [4:0]  sum5;
  logic [8:0]  sum9;
  logic [7:0]  src_b;
  logic        bit_sel;
  logic [7:0]  da;
  logic        msb;
  logic        res_zero;

  // operand fetch and full result compute in one combinational block
  always_comb begin
    op_a   = gpr_reg[alu_dst];
    op_b   = gpr_reg[alu_src];
    src_b  = alu_use_imm ? alu_imm : op_b[7:0];
    // byte ops act on the low half of the destination register
    if (!alu_word) begin
      op_a = {8'h00, op_a[7:0]};
      op_b = {8'h00, src_b};
    end
    res    = op_a;
    c_new  = flag_reg[`CRF_FLAG_CARRY];
    h_new  = flag_reg[`CRF_FLAG_HALF];
    v_new  = 1'b0;
    flags_arith = 1'b1;
    cin    = 1'b0;
    sum17  = 17'h00000;
    sum13  = 13'h0000;
    sum5   = 5'h00;
    sum9   = 9'h000;
    bit_sel = op_a[bit_num] ^ bit_inv;
    da     = op_a[7:0];
    case (alu_op)
      CRF_OP_ADD, CRF_OP_ADDC: begin
        cin   = (alu_op == CRF_OP_ADDC) ? flag_reg[`CRF_FLAG_CARRY] : 1'b0;
        sum17 = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, cin};
        sum13 = {1'b0, op_a[11:0]} + {1'b0, op_b[11:0]} + {12'h000, cin};
        sum5  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
        sum9  = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]} + {8'h00, cin};
        res   = sum17[15:0];
        c_new = alu_word ? sum17[16] : sum9[8];
        h_new = alu_word ? sum13[12] : sum5[4];
        v_new = alu_word ?
          (op_a[15] == op_b[15]) && (res[15] != op_a[15]) :
          (op_a[7] == op_b[7]) && (res[7] != op_a[7]);
      end
      CRF_OP_SUB, CRF_OP_SUBC, CRF_OP_CMP, CRF_OP_NEG: begin
        if (alu_op == CRF_OP_NEG) begin
          op_b = op_a;
          op_a = 16'h0000;
        end
        cin   = (alu_op == CRF_OP_SUBC) ? flag_reg[`CRF_FLAG_CARRY] : 1'b0;
        sum17 = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, cin};
        sum13 = {1'b0, op_a[11:0]} - {1'b0, op_b[11:0]} - {12'h000, cin};
        sum5  = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
        sum9  = {1'b0, op_a[7:0]} - {1'b0, op_b[7:0]} - {8'h00, cin};
        res   = sum17[15:0];
        c_new = alu_word ? sum17[16] : sum9[8];
        h_new = alu_word ? sum13[12] : sum5[4];
        v_new = alu_word ?
          (op_a[15] != op_b[15]) && (res[15] != op_a[15]) :
          (op_a[7] != op_b[7]) && (res[7] != op_a[7]);
      end
      CRF_OP_AND: res = op_a & op_b;
      CRF_OP_OR:  res = op_a | op_b;
      CRF_OP_XOR: res = op_a ^ op_b;
      CRF_OP_NOT: res = ~op_a;
      CRF_OP_SHL: begin
        res   = {op_a[14:0], 1'b0};
        c_new = op_a[7];
      end
      CRF_OP_SHR: begin
        res   = {1'b0, op_a[15:1]};
        c_new = op_a[0];
      end
      CRF_OP_ROTL: begin
        res   = {8'h00, op_a[6:0], op_a[7]};
        c_new = op_a[7];
      end
      CRF_OP_ROTR: begin
        res   = {8'h00, op_a[0], op_a[7:1]};
        c_new = op_a[0];
      end
      CRF_OP_DADJ_A: begin
        // packed bcd: each nibble one digit, half carry used implicitly
        if (flag_reg[`CRF_FLAG_HALF] || (op_a[3:0] > `CRF_NIB_HI))
          da = da + `CRF_BCD_LOW_FIX;
        if (flag_reg[`CRF_FLAG_CARRY] || (op_a[7:0] > `CRF_BCD_HI_LIMIT)) begin
          da    = da + `CRF_BCD_HIGH_FIX;
          c_new = 1'b1;
        end
        res = {8'h00, da};
      end
      CRF_OP_DADJ_S: begin
        if (flag_reg[`CRF_FLAG_HALF])
          da = da - `CRF_BCD_LOW_FIX;
        if (flag_reg[`CRF_FLAG_CARRY])
          da = da - `CRF_BCD_HIGH_FIX;
        res = {8'h00, da};
      end
      CRF_OP_INC_SM: begin
        // word only and leaves the flags alone
        res = gpr_reg[alu_dst] + (small_two ? `CRF_STEP_TWO : `CRF_STEP_ONE);
        flags_arith = 1'b0;
      end
      CRF_OP_DEC_SM: begin
        res = gpr_reg[alu_dst] - (small_two ? `CRF_STEP_TWO : `CRF_STEP_ONE);
        flags_arith = 1'b0;
      end
      CRF_OP_BIT_LD: begin
        c_new = bit_sel;
        flags_arith = 1'b0;
      end
      CRF_OP_BIT_AND: begin
        c_new = flag_reg[`CRF_FLAG_CARRY] & bit_sel;
        flags_arith = 1'b0;
      end
      CRF_OP_BIT_OR: begin
        c_new = flag_reg[`CRF_FLAG_CARRY] | bit_sel;
        flags_arith = 1'b0;
      end
      CRF_OP_BIT_XOR: begin
        c_new = flag_reg[`CRF_FLAG_CARRY] ^ bit_sel;
        flags_arith = 1'b0;
      end
      CRF_OP_MOVE: res = op_b;
      default: flags_arith = 1'b0;
    endcase
    msb      = alu_word ? res[15] : res[7];
    res_zero = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
    c_out = c_new;
    h_out = h_new;
    v_out = v_new;
  end

  // ==========================================================
  // general register writes
  // byte writes keep the other half untouched
  logic        res_write;
  assign res_write = alu_go && (alu_op != CRF_OP_CMP) &&
                     (alu_op < CRF_OP_BIT_LD || alu_op == CRF_OP_MOVE);

  always_ff @(posedge clk) begin
    if (wr_en) begin
      case (wr_size)
        CRF_SZ_WORD: gpr_reg[wr_idx]       <= wr_data;
        CRF_SZ_HIGH: gpr_reg[wr_idx][15:8] <= wr_data[7:0];
        CRF_SZ_LOW:  gpr_reg[wr_idx][7:0]  <= wr_data[7:0];
        default:     gpr_reg[wr_idx]       <= wr_data;
      endcase
    end else if (res_write) begin
      if (alu_word || alu_op == CRF_OP_INC_SM || alu_op == CRF_OP_DEC_SM)
        gpr_reg[alu_dst] <= res;
      else
        gpr_reg[alu_dst][7:0] <= res[7:0];
    end else if (push_req) begin
      // stack moves two bytes at a time, always a whole word
      gpr_reg[`CRF_STACK_IDX] <= sp_val - `CRF_STEP_TWO;
    end else if (pop_req) begin
      gpr_reg[`CRF_STACK_IDX] <= sp_val + `CRF_STEP_TWO;
    end
  end

  // ==========================================================
  // flag byte register
  // only the mask bit has a reset value; others stay as they were
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_mask_reg <= 1'b1;
    end else if (irq_entry) begin
      flag_mask_reg <= 1'b1;
    end else if (flag_src == CRF_FL_LOAD) begin
      flag_mask_reg <= flag_wdata[`CRF_FLAG_MASK];
    end else if (flag_src == CRF_FL_POP) begin
      flag_mask_reg <= pop_word[15];
    end
  end

  always_ff @(posedge clk) begin
    if (flag_src == CRF_FL_LOAD) begin
      flag_rest_reg <= flag_wdata[6:0];
    end else if (flag_src == CRF_FL_POP) begin
      flag_rest_reg <= pop_word[14:8];
    end else if (alu_go && flag_src == CRF_FL_ALU) begin
      flag_rest_reg[`CRF_FLAG_CARRY] <= c_out;
      if (flags_arith) begin
        if (alu_op <= CRF_OP_CMP)
          flag_rest_reg[`CRF_FLAG_HALF] <= h_out;
        flag_rest_reg[`CRF_FLAG_NEG]  <= msb;
        flag_rest_reg[`CRF_FLAG_ZERO] <= res_zero;
        flag_rest_reg[`CRF_FLAG_OVF]  <= v_out;
      end
    end
  end

  // ==========================================================
  // instruction pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ip_reg <= 16'h0000;
    end else if (ip_load) begin
      ip_reg <= ip_target & `CRF_EVEN_MASK;
    end else if (ip_step) begin
      ip_reg <= (ip_reg & `CRF_EVEN_MASK) + `CRF_STEP_TWO;
    end
  end

  // pending flag set by reset, cleared on the first clock after release; the vector is never loaded
  logic vec_pend_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) vec_pend_reg <= 1'b1;
    else     vec_pend_reg <= 1'b0;
  end

  // ==========================================================
  // condition evaluation
  logic fn;
  logic fz;
  logic fv;
  logic fc;
  logic cond_next;
  always_comb begin
    fn = flag_reg[`CRF_FLAG_NEG];
    fz = flag_reg[`CRF_FLAG_ZERO];
    fv = flag_reg[`CRF_FLAG_OVF];
    fc = flag_reg[`CRF_FLAG_CARRY];
    case (cond_sel)
      CRF_CC_T:  cond_next = 1'b1;
      CRF_CC_F:  cond_next = 1'b0;
      CRF_CC_HI: cond_next = !(fc | fz);
      CRF_CC_LS: cond_next = fc | fz;
      CRF_CC_CC: cond_next = !fc;
      CRF_CC_CS: cond_next = fc;
      CRF_CC_NE: cond_next = !fz;
      CRF_CC_EQ: cond_next = fz;
      CRF_CC_VC: cond_next = !fv;
      CRF_CC_VS: cond_next = fv;
      CRF_CC_PL: cond_next = !fn;
      CRF_CC_MI: cond_next = fn;
      CRF_CC_GE: cond_next = !(fn ^ fv);
      CRF_CC_LT: cond_next = fn ^ fv;
      CRF_CC_GT: cond_next = !(fz | (fn ^ fv));
      CRF_CC_LE: cond_next = fz | (fn ^ fv);
      default:   cond_next = 1'b0;
    endcase
  end

  // ==========================================================
  // registered outputs
  logic [15:0] rd_raw;
  always_comb begin
    rd_raw = gpr_reg[rd_idx];
    case (rd_size)
      CRF_SZ_HIGH: rd_raw = {8'h00, gpr_reg[rd_idx][15:8]};
      CRF_SZ_LOW:  rd_raw = {8'h00, gpr_reg[rd_idx][7:0]};
      default:     rd_raw = gpr_reg[rd_idx];
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data            <= 16'h0000;
      addr_out           <= 16'h0000;
      ip_out             <= 16'h0000;
      flag_byte_register <= 8'h00;
      stack_top_pointer  <= 16'h0000;
      stack_addr         <= 16'h0000;
      stack_wdata        <= 16'h0000;
      mem_addr_out       <= 16'h0000;
      int_masked         <= 1'b1;
      cond_true          <= 1'b0;
    end else begin
      rd_data            <= rd_raw;
      addr_out           <= gpr_reg[addr_idx];
      ip_out             <= ip_reg & `CRF_EVEN_MASK;
      flag_byte_register <= flag_reg;
      stack_top_pointer  <= sp_val;
      // push address is the word below the current top
      stack_addr <= (push_req ? sp_val - `CRF_STEP_TWO : sp_val)
                    & `CRF_EVEN_MASK;
      stack_wdata <= push_flags ? {flag_reg, flag_reg}
                                : gpr_reg[alu_src];
      mem_addr_out <= mem_word ? (mem_addr_in & `CRF_EVEN_MASK)
                               : mem_addr_in;
      int_masked <= flag_reg[`CRF_FLAG_MASK];
      cond_true  <= cond_next;
    end
  end

  // reset vector only compared with ip_reg; the result drives nothing
  logic unused_vec;
  assign unused_vec = vec_pend_reg & (reset_vector != ip_reg);

endmodule : crf_core
`default_nettype wire

// ---- hdl/crf_params.svh ----
// constants for the cpu register and flag unit
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

// flag byte bit positions
`define CRF_FLAG_MASK    7
`define CRF_FLAG_USER_HI 6
`define CRF_FLAG_HALF    5
`define CRF_FLAG_USER_LO 4
`define CRF_FLAG_NEG     3
`define CRF_FLAG_ZERO    2
`define CRF_FLAG_OVF     1
`define CRF_FLAG_CARRY   0

// widths, indices and arithmetic constants
`define CRF_WORD_W       16
`define CRF_BYTE_W       8
`define CRF_REG_CNT      8
`define CRF_STACK_IDX    3'h7
`define CRF_BYTE_NIB_MSB 3
`define CRF_WORD_NIB_MSB 11
`define CRF_NIB_HI       4'h9
`define CRF_BCD_LOW_FIX  8'h06
`define CRF_BCD_HIGH_FIX 8'h60
`define CRF_BCD_HI_LIMIT 8'h99
`define CRF_STEP_ONE     16'h0001
`define CRF_STEP_TWO     16'h0002
`define CRF_EVEN_MASK    16'hFFFE

`endif

// ---- hdl/crf_pkg.sv ----
// types shared by the cpu register and flag unit
package crf_pkg;

  // operation selector for the flag/arith path
  typedef enum logic [4:0] {
    CRF_OP_NONE    = 5'b00000,
    CRF_OP_ADD     = 5'b00001,
    CRF_OP_ADDC    = 5'b00010,
    CRF_OP_SUB     = 5'b00011,
    CRF_OP_SUBC    = 5'b00100,
    CRF_OP_NEG     = 5'b00101,
    CRF_OP_CMP     = 5'b00110,
    CRF_OP_AND     = 5'b00111,
    CRF_OP_OR      = 5'b01000,
    CRF_OP_XOR     = 5'b01001,
    CRF_OP_NOT     = 5'b01010,
    CRF_OP_SHL     = 5'b01011,
    CRF_OP_SHR     = 5'b01100,
    CRF_OP_ROTL    = 5'b01101,
    CRF_OP_ROTR    = 5'b01110,
    CRF_OP_DADJ_A  = 5'b01111,
    CRF_OP_DADJ_S  = 5'b10000,
    CRF_OP_INC_SM  = 5'b10001,
    CRF_OP_DEC_SM  = 5'b10010,
    CRF_OP_BIT_LD  = 5'b10011,
    CRF_OP_BIT_AND = 5'b10100,
    CRF_OP_BIT_OR  = 5'b10101,
    CRF_OP_BIT_XOR = 5'b10110,
    CRF_OP_MOVE    = 5'b10111
  } crf_op_e;

  // operand size
  typedef enum logic [1:0] {
    CRF_SZ_LOW  = 2'b00,
    CRF_SZ_HIGH = 2'b01,
    CRF_SZ_WORD = 2'b10
  } crf_size_e;

  // branch condition codes
  typedef enum logic [3:0] {
    CRF_CC_T   = 4'h0,
    CRF_CC_F   = 4'h1,
    CRF_CC_HI  = 4'h2,
    CRF_CC_LS  = 4'h3,
    CRF_CC_CC  = 4'h4,
    CRF_CC_CS  = 4'h5,
    CRF_CC_NE  = 4'h6,
    CRF_CC_EQ  = 4'h7,
    CRF_CC_VC  = 4'h8,
    CRF_CC_VS  = 4'h9,
    CRF_CC_PL  = 4'hA,
    CRF_CC_MI  = 4'hB,
    CRF_CC_GE  = 4'hC,
    CRF_CC_LT  = 4'hD,
    CRF_CC_GT  = 4'hE,
    CRF_CC_LE  = 4'hF
  } crf_cond_e;

  // flag source
  typedef enum logic [1:0] {
    CRF_FL_HOLD = 2'b00,
    CRF_FL_ALU  = 2'b01,
    CRF_FL_LOAD = 2'b10,
    CRF_FL_POP  = 2'b11
  } crf_flsrc_e;

endpackage : crf_pkg

// ---- tb/crf_core_props.sv ----
// concurrent checks for the cpu register and flag unit
`timescale 1ns/1ps
`default_nettype none
module crf_core_props
  import crf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic        alu_go,
  input wire logic        push_req,
  input wire logic        push_flags,
  input wire logic        pop_req,
  input wire logic        irq_entry,
  input wire crf_flsrc_e  flag_src,
  input wire logic        ip_load,
  input wire logic [15:0] ip_target,
  input wire logic        ip_step,
  input wire logic [15:0] mem_addr_in,
  input wire logic        mem_word,
  input wire crf_cond_e   cond_sel,
  input wire logic [15:0] ip_out,
  input wire logic [7:0]  flag_byte_register,
  input wire logic [15:0] stack_top_pointer,
  input wire logic [15:0] stack_wdata,
  input wire logic [15:0] mem_addr_out,
  input wire logic        int_masked,
  input wire logic        cond_true
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================
  // helper: nothing else moves register seven
  wire logic quiet;
  assign quiet = !wr_en && !alu_go && !push_req && !pop_req;

  // ==========================================
  // mask, instruction pointer, alignment
  AST_MASK_MIRROR: assert property (!$past(rst) |->
    int_masked == flag_byte_register[7]) else $error("mask copy differs");
  AST_RESET_MASK: assert property ($past(rst) |-> int_masked)
    else $error("mask low right after reset");
  AST_IRQ_MASK: assert property (irq_entry && flag_src == CRF_FL_HOLD
    ##1 flag_src == CRF_FL_HOLD |-> ##1 int_masked)
    else $error("interrupt entry left mask clear");
  AST_IP_EVEN: assert property (ip_out[0] == 1'b0)
    else $error("instruction pointer odd");
  AST_IP_LOAD: assert property (ip_load && !ip_step ##1
    !ip_load && !ip_step |-> ##1 ip_out == ($past(ip_target, 2) & 16'hFFFE))
    else $error("instruction pointer load wrong");
  AST_MEM_WORD: assert property (mem_word |=>
    mem_addr_out == ($past(mem_addr_in) & 16'hFFFE))
    else $error("word address not aligned");
  AST_MEM_BYTE: assert property (!mem_word |=>
    mem_addr_out == $past(mem_addr_in)) else $error("byte address changed");

  // ==========================================
  // stack word handling and branch conditions
  AST_PUSH_STEP: assert property (push_req && !wr_en && !alu_go &&
    !pop_req ##1 quiet |-> ##1
    stack_top_pointer == $past(stack_top_pointer) - 16'h0002)
    else $error("push did not step by one word");
  AST_POP_STEP: assert property (pop_req && !wr_en && !alu_go &&
    !push_req ##1 quiet |-> ##1
    stack_top_pointer == $past(stack_top_pointer) + 16'h0002)
    else $error("pop did not step by one word");
  AST_FLAG_PUSH: assert property (push_req && push_flags |->
    ##[1:2] stack_wdata == {flag_byte_register, flag_byte_register})
    else $error("flag push not two copies");
  AST_COND_FIXED: assert property (cond_sel inside {CRF_CC_T, CRF_CC_F}
    |=> cond_true == ($past(cond_sel) == CRF_CC_T))
    else $error("fixed condition wrong");
  AST_COND_LT: assert property (cond_sel == CRF_CC_LT |=>
    cond_true == (flag_byte_register[3] ^ flag_byte_register[1]))
    else $error("sign condition wrong");

  // main scenarios reached
  COV_PUSH: cover property (push_req && push_flags);
  COV_POP: cover property (pop_req && flag_src == CRF_FL_POP);
  COV_IRQ: cover property (irq_entry);
endmodule : crf_core_props

bind crf_core crf_core_props u_props (.clk, .rst, .wr_en, .alu_go,
  .push_req, .push_flags, .pop_req, .irq_entry, .flag_src, .ip_load,
  .ip_target, .ip_step, .mem_addr_in, .mem_word, .cond_sel, .ip_out,
  .flag_byte_register, .stack_top_pointer, .stack_wdata, .mem_addr_out,
  .int_masked, .cond_true);
`default_nettype wire

// ---- tb/crf_core_test.sv ----
// self-checking bench for the cpu register and flag unit
`timescale 1ns/1ps
`default_nettype none
module crf_core_test
  import crf_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reset_vector = 16'h1235;
  logic        wr_en, alu_go, alu_word, bit_inv, alu_use_imm, small_two;
  logic        push_req, push_flags, pop_req, irq_entry, ip_load, ip_step;
  logic        mem_word, int_masked, cond_true;
  logic [2:0]  wr_idx, rd_idx, addr_idx, alu_dst, alu_src, bit_num;
  logic [7:0]  alu_imm, flag_wdata, flag_byte_register, fl;
  logic [15:0] wr_data, pop_word, ip_target, mem_addr_in, rd_data, addr_out;
  logic [15:0] ip_out, stack_top_pointer, stack_wdata, mem_addr_out;
  logic [15:0] stack_addr;
  crf_size_e   wr_size, rd_size;
  crf_op_e     alu_op;
  crf_flsrc_e  flag_src;
  crf_cond_e   cond_sel;
  logic [15:0] gpr [8];
  logic [31:0] rnd = 32'h0000E474;
  int          failures = 0, tests_run = 0, cycles = 0;
  crf_op_e     ops [6] = '{CRF_OP_ADD, CRF_OP_SUB, CRF_OP_CMP, CRF_OP_NEG,
                           CRF_OP_INC_SM, CRF_OP_DEC_SM};

  // ==========================================
  // clock, design, hang guard
  initial begin
    forever #12.5 clk = ~clk;
  end

  crf_core i_dut (
    .clk, .rst, .reset_vector, .wr_en, .wr_idx, .wr_size, .wr_data, .rd_idx,
    .rd_size, .addr_idx, .alu_go, .alu_op, .alu_word, .alu_dst, .alu_src,
    .alu_imm, .alu_use_imm, .bit_num, .bit_inv, .small_two, .flag_src,
    .flag_wdata, .pop_word, .push_req, .push_flags, .pop_req, .irq_entry,
    .ip_load, .ip_target, .ip_step, .mem_addr_in, .mem_word, .cond_sel,
    .rd_data, .addr_out, .ip_out, .flag_byte_register, .stack_top_pointer,
    .stack_addr, .stack_wdata, .mem_addr_out, .int_masked, .cond_true
  );

  // the whole run needs under nine hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================
  // helpers
  function automatic logic [15:0] rand16();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[15:0];
  endfunction : rand16

  // odd codes are the inverse of the even code below them
  function automatic logic cond_exp(input int c);
    logic [7:0] t;
    t = {!(fl[2] | (fl[3] ^ fl[1])), fl[3] == fl[1], !fl[3], !fl[1],
         !fl[2], !fl[0], !(fl[0] | fl[2]), 1'b1};
    return t[c / 2] ^ c[0];
  endfunction : cond_exp

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic idle();
    {wr_en, alu_go, push_req, push_flags, pop_req} = '0;
    {irq_entry, ip_load, ip_step} = '0;
    flag_src = CRF_FL_HOLD;
  endtask : idle

  // one edge with strobes up, then room for state plus output stage
  task automatic pulse();
    tick(1);
    idle();
    tick(3);
  endtask : pulse

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wreg(input logic [2:0] i, input crf_size_e sz,
                      input logic [15:0] d);
    wr_en = 1'b1;
    wr_idx = i;
    wr_size = sz;
    wr_data = d;
    if (sz == CRF_SZ_WORD) gpr[i] = d;
    else if (sz == CRF_SZ_HIGH) gpr[i][15:8] = d[7:0];
    else gpr[i][7:0] = d[7:0];
    pulse();
  endtask : wreg

  task automatic rdchk(input logic [2:0] i, input crf_size_e sz);
    logic [15:0] e;
    rd_idx = i;
    rd_size = sz;
    addr_idx = i;
    e = sz == CRF_SZ_WORD ? gpr[i] : {8'h00, gpr[i][7:0]};
    if (sz == CRF_SZ_HIGH) e = {8'h00, gpr[i][15:8]};
    tick(3);
    check(rd_data, e);
    check(addr_out, gpr[i]);
  endtask : rdchk

  // model of one operation: flags from integer arithmetic
  task automatic alu(input crf_op_e op, input logic w);
    int a, b, r, m, hm, sb, c, h, v;
    logic [15:0] x;
    x = rand16();
    alu_dst = x[2:0];
    alu_src = x[5:3];
    small_two = x[6];
    alu_op = op;
    alu_word = w;
    alu_go = 1'b1;
    flag_src = CRF_FL_ALU;
    m = w ? 'hFFFF : 'hFF;
    hm = w ? 'hFFF : 'hF;
    sb = w ? 15 : 7;
    a = gpr[alu_dst] & m;
    b = gpr[alu_src] & m;
    if (op == CRF_OP_INC_SM || op == CRF_OP_DEC_SM) begin
      flag_src = CRF_FL_HOLD;
      r = small_two ? 2 : 1;
      r = op == CRF_OP_INC_SM ? a + r : a - r;
      gpr[alu_dst] = r[15:0];
    end else begin
      if (op == CRF_OP_NEG) begin
        b = a;
        a = 0;
      end
      r = op == CRF_OP_ADD ? a + b : a - b;
      c = op == CRF_OP_ADD ? r > m : a < b;
      h = op == CRF_OP_ADD ? (a & hm) + (b & hm) > hm : (a & hm) < (b & hm);
      v = op == CRF_OP_ADD ? (a ^ r) & (b ^ r) : (a ^ b) & (a ^ r);
      v = v >> sb;
      fl = {fl[7:6], h[0], fl[4], r[sb], (r & m) == 0, v[0], c[0]};
      if (op != CRF_OP_CMP && w) gpr[alu_dst] = r[15:0];
      if (op != CRF_OP_CMP && !w) gpr[alu_dst][7:0] = r[7:0];
    end
    pulse();
    check(flag_byte_register, fl);
    rdchk(alu_dst, CRF_SZ_WORD);
  endtask : alu

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // ==========================================
  // main sequence
  initial begin
    logic [15:0] x;
    idle();
    {wr_idx, rd_idx, addr_idx, alu_dst, alu_src, bit_num} = '0;
    {bit_inv, alu_use_imm, small_two, alu_word, mem_word} = '0;
    {wr_data, pop_word, ip_target, mem_addr_in, alu_imm, flag_wdata} = '0;
    wr_size = CRF_SZ_WORD;
    rd_size = CRF_SZ_WORD;
    alu_op = CRF_OP_NONE;
    cond_sel = CRF_CC_T;
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    check(int_masked, 1'b1);
    tick(2);
    check(flag_byte_register[7], 1'b1);
    ip_target = reset_vector;
    ip_load = 1'b1;
    pulse();
    check(ip_out, reset_vector & 16'hFFFE);
    ip_step = 1'b1;
    pulse();
    check(ip_out, (reset_vector & 16'hFFFE) + 16'h0002);
    for (int i = 0; i < 8; i++) wreg(i[2:0], CRF_SZ_WORD, rand16());
    for (int i = 0; i < 24; i++) begin
      x = rand16();
      wreg(x[2:0], crf_size_e'(i % 3), {2{x[15:8]}});
      rdchk(x[2:0], crf_size_e'((i + 1) % 3));
    end
    flag_src = CRF_FL_LOAD;
    flag_wdata = 8'h50;
    fl = 8'h50;
    pulse();
    check(flag_byte_register, fl);
    check(int_masked, 1'b0);
    irq_entry = 1'b1;
    fl[7] = 1'b1;
    pulse();
    check(flag_byte_register, fl);
    for (int i = 0; i < 60; i++) alu(ops[i % 6], i % 6 > 3 || i / 6 % 2 == 1);
    x = rand16() & 16'hFFFE;
    wreg(3'h7, CRF_SZ_WORD, x);
    push_req = 1'b1;
    push_flags = 1'b1;
    // push data stands only while the push is asserted
    tick(1);
    check(stack_wdata, {fl, fl});
    check(stack_addr, x - 16'h0002);
    idle();
    tick(3);
    check(stack_top_pointer, x - 16'h0002);
    pop_word = rand16();
    pop_req = 1'b1;
    flag_src = CRF_FL_POP;
    pulse();
    check(stack_top_pointer, x);
    check(flag_byte_register, pop_word[15:8]);
    for (int i = 0; i < 16; i++) begin
      mem_addr_in = rand16();
      mem_word = i[0];
      tick(2);
      check(mem_addr_out, mem_addr_in & {15'h7FFF, !mem_word});
    end
    for (int i = 0; i < 64; i++) begin
      if (i % 16 == 0) begin
        x = rand16();
        flag_src = CRF_FL_LOAD;
        flag_wdata = x[7:0];
        fl = x[7:0];
        pulse();
      end
      cond_sel = crf_cond_e'(i % 16);
      tick(2);
      check(cond_true, cond_exp(i % 16));
    end
    conclude();
  end
endmodule : crf_core_test
`default_nettype wire
